// file: inc/dll_seq_pkg.sv
// constants and carrier types for the dll initialization sequencer
// assumes a single 25 MHz core clock domain
package dll_seq_pkg;
  localparam int unsigned clk_period_ns = 40;
  // stop threshold: clock static for more than this is a dll reset
  localparam int unsigned stop_time_ns = 30;
  // longest time rounds down, never below one cycle
  localparam int unsigned stop_cycles_raw = stop_time_ns / clk_period_ns;
  localparam int unsigned stop_cycles = (stop_cycles_raw < 1) ? 1 : stop_cycles_raw;
  // lock interval in cycles of stable clock
  localparam int unsigned dll_lock_interval = 2048;
  localparam int unsigned cnt_w = 12;
  // last count of the lock interval, counted from zero
  localparam logic [cnt_w-1:0] lock_last = cnt_w'(dll_lock_interval - 1);
  localparam logic [3:0] stop_last = 4'(stop_cycles);
  localparam logic [3:0] stop_zero = 4'h0;
  localparam logic [cnt_w-1:0] cnt_zero = 12'h000;

  typedef enum logic [1:0] {st_init, st_ready} seq_state_t;

  typedef struct packed {
    logic ready;       // normal commands accepted
    logic dll_locked;  // loop aligned to clock
    logic dll_bypass;  // one-cycle latency mode
  } seq_status_t;
endpackage

// file: rtl/clk_stop_detect.sv
// detects a static command clock pair (k and k#) sampled on core_clk
// assumes the clock levels arrive synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module clk_stop_detect (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic k_in,
  input wire logic k_n_in,
  output logic stopped
);
  logic k_prev_ff;
  logic kn_prev_ff;
  logic [3:0] idle_ff;
  logic toggled;

  assign toggled = (k_in != k_prev_ff) && (k_n_in != kn_prev_ff);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      k_prev_ff <= 1'b0;
      kn_prev_ff <= 1'b0;
    end else begin
      k_prev_ff <= k_in;
      kn_prev_ff <= k_n_in;
    end
  end

  // either clock static for more than the threshold counts as stopped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_ff <= dll_seq_pkg::stop_zero;
    end else if (toggled) begin
      idle_ff <= dll_seq_pkg::stop_zero;
    end else if (idle_ff <= dll_seq_pkg::stop_last) begin
      idle_ff <= idle_ff + 4'h1;
    end
  end

  assign stopped = (idle_ff > dll_seq_pkg::stop_last);
endmodule
`default_nettype wire

// file: rtl/dll_init_sequencer.sv
// power-up and dll reset sequencer of a burst sram
// assumes k and k# levels are sampled on core_clk; resetn models power-on
// Contract
// RULE_01: stay unavailable after stable clock until lock interval cycles elapse.
// RULE_02: during lock interval initialize logic and lock the dll.
// RULE_03: dll-disable low skips dll locking, only logic initialization runs.
// RULE_04: with dll-disable tied low, ready after lock interval of stable clock.
// RULE_05: controller raises dll-disable only after stable clock, then waits.
// RULE_06: dll-disable raised too early needs a dll reset by the controller.
// RULE_07: either clock static beyond the stop threshold resets the dll.
// RULE_08: after dll reset relock within lock interval, then become ready.
// RULE_09: low-to-high on dll-disable resets the dll and restarts locking.
// RULE_10: controller issues a dll reset when changing frequency.
// RULE_11: controller holds all inputs at defined levels during power-up.
// RULE_12: dll lock is reached after 2048 stable clock cycles from reset.
// RULE_13: bypassed dll gives one-cycle read latency and longer access.
// RULE_14: controller blocks commands until the lock interval has elapsed.
`timescale 1ns/100ps
`default_nettype none
module dll_init_sequencer (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic dll_enable_n_in,
  output var dll_seq_pkg::seq_status_t status,
  output logic [1:0] read_latency
);
  dll_seq_pkg::seq_state_t state_ff;
  logic [dll_seq_pkg::cnt_w-1:0] lock_cnt_ff;
  logic dll_en_prev_ff;
  logic dll_locked_ff;
  logic ready_ff;
  logic bypass_ff;
  logic [1:0] latency_ff;
  logic stopped;
  logic rise;
  logic restart;
  logic done;

  clk_stop_detect u_stop (
    .core_clk(core_clk),
    .resetn(resetn),
    .k_in(k_in),
    .k_n_in(k_n_in),
    .stopped(stopped)
  );

  // the pin is named as an enable here: high lets the dll run
  assign rise = dll_enable_n_in && !dll_en_prev_ff;  // [RULE_09]
  // a stopped clock holds the sequence at its start until clock returns
  assign restart = stopped || rise;  // [RULE_07] [RULE_09]
  assign done = (lock_cnt_ff == dll_seq_pkg::lock_last);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dll_en_prev_ff <= 1'b0;
    end else begin
      dll_en_prev_ff <= dll_enable_n_in;
    end
  end

  // lock interval counts only cycles of stable clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_cnt_ff <= dll_seq_pkg::cnt_zero;
    end else if (restart) begin
      lock_cnt_ff <= dll_seq_pkg::cnt_zero;  // [RULE_08]
    end else if (state_ff == dll_seq_pkg::st_init && !done) begin
      lock_cnt_ff <= lock_cnt_ff + 12'h001;  // [RULE_01] [RULE_12]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= dll_seq_pkg::st_init;
    end else begin
      unique case (state_ff)
        dll_seq_pkg::st_init: begin
          if (!restart && done) begin
            state_ff <= dll_seq_pkg::st_ready;  // [RULE_01] [RULE_04]
          end
        end
        dll_seq_pkg::st_ready: begin
          if (restart) begin
            state_ff <= dll_seq_pkg::st_init;  // [RULE_07] [RULE_08]
          end
        end
        default: begin
          state_ff <= dll_seq_pkg::st_init;
        end
      endcase
    end
  end

  // the same interval both initializes logic and locks the loop;
  // with the dll disabled locking is skipped and only init runs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dll_locked_ff <= 1'b0;
    end else if (restart || !dll_enable_n_in) begin
      dll_locked_ff <= 1'b0;  // [RULE_03]
    end else if (state_ff == dll_seq_pkg::st_init && done) begin
      dll_locked_ff <= 1'b1;  // [RULE_02] [RULE_12]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (state_ff == dll_seq_pkg::st_init) && !restart && done;  // [RULE_01]
      if (state_ff == dll_seq_pkg::st_ready && !restart) begin
        ready_ff <= 1'b1;
      end
    end
  end

  // bypass mode: one cycle read latency instead of dll-aligned timing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bypass_ff <= 1'b1;
      latency_ff <= 2'h1;
    end else begin
      bypass_ff <= !dll_enable_n_in;  // [RULE_13]
      latency_ff <= dll_enable_n_in ? 2'h2 : 2'h1;  // [RULE_13]
    end
  end

  assign status.ready = ready_ff;
  assign status.dll_locked = dll_locked_ff;
  assign status.dll_bypass = bypass_ff;
  assign read_latency = latency_ff;
endmodule
`default_nettype wire

// file: verification/dll_seq_checker.sv
// port assertions for the dll init sequencer
// assumes k pair levels are sampled on core_clk
`timescale 1ns/100ps
`default_nettype none
module dll_seq_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic dll_enable_n_in,
  input wire dll_seq_pkg::seq_status_t status,
  input wire logic [1:0] read_latency
);
  logic pk_ff, pkn_ff, tog;
  logic [11:0] run_ff;
  assign tog = (k_in != pk_ff) && (k_n_in != pkn_ff);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pk_ff <= 1'b0;
      pkn_ff <= 1'b1;
    end else begin
      pk_ff <= k_in;
      pkn_ff <= k_n_in;
    end
  end
  // saturates so a long lock never wraps back below the interval
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_ff <= 12'h000;
    end else if (!tog) begin
      run_ff <= 12'h000;
    end else if (run_ff != 12'hfff) begin
      run_ff <= run_ff + 12'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ready_gate_a:
    assert property ($rose(status.ready) |-> run_ff > 12'h7f0) else $error("early ready");
  lock_gate_a:
    assert property ($rose(status.dll_locked) |-> run_ff > 12'h7f0) else $error("early lock");
  stop_drop_a:
    assert property (!tog ##1 !tog |-> ##[1:3] !status.ready) else $error("stop ignored");
  pin_drop_a:
    assert property ($rose(dll_enable_n_in) |-> ##[1:3] !status.ready) else $error("pin ignored");
  bypass_lat_a:
    assert property (!dll_enable_n_in [*2] |-> status.dll_bypass && read_latency == 2'h1)
      else $error("bypass mode");
  dll_lat_a:
    assert property ((dll_enable_n_in && $past(resetn)) [*2] |->
      !status.dll_bypass && read_latency == 2'h2)
      else $error("dll mode");
  bypass_nolock_a:
    assert property (status.dll_bypass [*2] |-> !status.dll_locked) else $error("lock in bypass");
  ready_hold_a:
    assert property (status.ready && tog && $past(tog) && $stable(dll_enable_n_in) |=>
      status.ready)
      else $error("ready lost");
endmodule
bind dll_init_sequencer dll_seq_checker chk_i (.core_clk(core_clk), .resetn(resetn),
  .k_in(k_in), .k_n_in(k_n_in), .dll_enable_n_in(dll_enable_n_in), .status(status),
  .read_latency(read_latency));
`default_nettype wire

// file: verification/ctrl_model.sv
// controller model driving the command clock pair
// assumes run is driven on the core_clk rising edge
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
  input wire logic core_clk,
  input wire logic run,
  output logic k_in,
  output logic k_n_in
);
  initial k_in = 1'b0; // defined level from power-on
  // clock toggles each cycle while run is high; a stop leaves it static
  always @(posedge core_clk) if (run) k_in <= ~k_in;
  assign k_n_in = ~k_in;
endmodule
`default_nettype wire

// file: verification/sram_dll_init_sequencer_tb_top.sv
// bench: locks, pin restart and clock stops against cycle-count bounds
// assumes ctrl_model drives the clock pair
`timescale 1ns/100ps
`default_nettype none
module sram_dll_init_sequencer_tb_top;
  logic core_clk = 1'b0, resetn = 1'b0, run = 1'b0, en_n = 1'b0, k_in, k_n_in;
  dll_seq_pkg::seq_status_t status;
  logic [1:0] read_latency;
  int n_mismatch = 0, num_checks = 0;
  always #20 core_clk = ~core_clk;
  ctrl_model ctl (.core_clk(core_clk), .run(run), .k_in(k_in), .k_n_in(k_n_in));
  dll_init_sequencer dut (.core_clk(core_clk), .resetn(resetn), .k_in(k_in),
    .k_n_in(k_n_in), .dll_enable_n_in(en_n), .status(status), .read_latency(read_latency));
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // commands stay blocked until ready, bounded wait
  task automatic lock(input logic byp);
    int n;
    n = 0;
    while (status.ready !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n < 2040) chk(5'(status.ready), 5'h0);
      if (n > 2070) begin
        chk(5'(status.ready), 5'h1);
        summarize();
      end
    end
    chk({status, read_latency}, {1'b1, ~byp, byp, byp ? 2'h1 : 2'h2});
    $display("test done, ready after %0d cycles", n);
  endtask
  task automatic drop;
    repeat (3) @(negedge core_clk);
    chk(5'(status.ready), 5'h0);
  endtask
  initial begin
    void'($urandom(32'h3a659306));
    repeat (10) @(posedge core_clk);
    chk({status, read_latency}, 5'h05);
    resetn <= 1'b1;
    run <= 1'b1;
    lock(1'b1); // pin tied low
    @(posedge core_clk) en_n <= 1'b1;
    drop();
    lock(1'b0);
    repeat (3) begin
      @(posedge core_clk) run <= 1'b0;
      repeat (2 + $urandom % 4) @(posedge core_clk);
      run <= 1'b1;
      drop();
      lock(1'b0);
    end
    // power cycle with the pin already high and a ragged clock
    @(posedge core_clk) resetn <= 1'b0;
    run <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk({status, read_latency}, 5'h05);
    resetn <= 1'b1;
    repeat (20) @(posedge core_clk) run <= 1'($urandom);
    // pin rose before the clock was stable, so stop the clock to reset
    @(posedge core_clk) run <= 1'b0;
    repeat (3) @(posedge core_clk);
    run <= 1'b1;
    drop();
    lock(1'b0);
    summarize();
  end
endmodule
`default_nettype wire
